// [inc/tmsk_pkg.sv]
// constants and types shared by the tandem connection monitor sink
// assumes a SystemVerilog elaborator; no other dependencies
`default_nettype none

package tmsk_pkg;

    // --------------------------------------------------------------
    // line framing
    // --------------------------------------------------------------
    localparam int unsigned POS_W = 12;
    localparam int unsigned EM_POS_DEF = 2;
    localparam int unsigned NR_POS_DEF = 5;
    localparam int unsigned CNT_W_DEF = 14;

    // --------------------------------------------------------------
    // multiframe in bits 7 and 8 of the overhead byte
    // --------------------------------------------------------------
    localparam logic [11:0] FAS_PAT = 12'hffe;
    localparam logic [6:0] MF_LEN = 7'h4c;
    localparam logic [6:0] FAS_END = 7'h06;
    localparam logic [6:0] TTI_FIRST = 7'h09;
    localparam logic [6:0] TTI_LAST = 7'h48;
    localparam logic [6:0] RDI_POS = 7'h49;
    localparam logic [6:0] ODI_POS = 7'h4a;
    localparam int unsigned TRACE_W = 128;
    localparam logic [1:0] TRACE_ACC_N = 2'h3;

    // --------------------------------------------------------------
    // persistence, modes and reset values
    // --------------------------------------------------------------
    localparam int unsigned UNEQ_N = 5;
    localparam int unsigned REMOTE_N = 5;
    localparam logic [7:0] UNEQ_CODE = 8'h00;
    localparam logic TPM_MON = 1'b1;
    localparam logic REPORT_EN_RST = 1'b0;

    typedef enum logic {
        TMSK_OOM = 1'b0,
        TMSK_IM = 1'b1
    } tmsk_mf_t;

endpackage: tmsk_pkg

`default_nettype wire

// [hdl/tmsk_persist.sv]
// persistence filter: state flips after n consecutive opposite samples
// assumes sample is a one-cycle pulse on clk; rst synchronous, high
`default_nettype none

module tmsk_persist #(
    parameter int unsigned N = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample,
    input wire logic bit_in,
    output logic state_q
);

    logic [3:0] run_q;
    logic last_run;

    assign last_run = run_q == 4'(N - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= 1'b0;
            run_q <= 4'h0;
        end else if (sample) begin
            if (bit_in == state_q) begin
                run_q <= 4'h0;
            end else if (last_run) begin
                state_q <= bit_in; // [RQ13] [RQ18]
                run_q <= 4'h0;
            end else begin
                run_q <= run_q + 4'h1;
            end
        end
    end

    persist_flip_a: assert property ( // [RQ13]
        @(posedge clk) disable iff (rst)
        $changed(state_q) |-> $past(sample && last_run && bit_in != state_q))
        else $error("filter flipped without a full run of samples");

endmodule: tmsk_persist

`default_nettype wire

// [hdl/tmsk_sink.sv]
// tandem connection non-intrusive monitor sink, top level
// assumes line_* and server_fail_in are synchronous to line_clk;
// management inputs and one_second are synchronous to ref_clk
//
// Summary of operation
// RQ1 - per-bit even parity of previous frame compared with received parity byte
// RQ2 - mismatch count minus incoming error code; nonzero magnitude is near errored block
// RQ3 - any parity mismatch in a frame flags an errored outgoing block
// RQ4 - incoming error code is bits 1 to 4, used unfiltered
// RQ5 - trace recovered from bits 7-8, frames 9 to 72, shown as accepted trace
// RQ6 - only trace mode 1 is handled
// RQ7 - remote error from bit 5, remote defect from bit 8 at frame 73
// RQ8 - remote defect bit 1 means defect, 0 means normal
// RQ9 - outgoing error bit 6, outgoing defect bit 7 at frame 74, 1 is defect
// RQ10 - multiframe found by searching bits 7-8 for 1111 1111 1110
// RQ11 - two consecutive errored alignment patterns lead to out of multiframe
// RQ12 - one clean alignment pattern returns to in multiframe
// RQ13 - unequipped after five zero overhead bytes, cleared after five others
// RQ14 - connection loss defect is active exactly while out of multiframe
// RQ15 - trace mismatch detected and cleared well within one second
// RQ16 - trace mismatch held off during server fail or when disabled
// RQ17 - degrade defect from parity violations, threshold and period from management
// RQ18 - remote and outgoing defects pass through a persistence filter
// RQ19 - trail fail from server fail or defects; trail degrade follows degrade
// RQ20 - causes prioritised: unequipped, connection loss, mismatch, then degrade; degrade is not gated by unequipped
// RQ21 - server fail and remote causes need report enables; remote ones need no unequipped, connection loss or mismatch defect (server fail does not gate them)
// RQ22 - the three report enables reset to disabled
// RQ23 - per second block counts and defect seconds, near, far and outgoing far
// RQ24 - monitoring on when termination point mode is monitored
`default_nettype none

module tmsk_sink #(
    parameter int unsigned EM_POS = tmsk_pkg::EM_POS_DEF,
    parameter int unsigned NR_POS = tmsk_pkg::NR_POS_DEF,
    parameter int unsigned CNT_W = tmsk_pkg::CNT_W_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic line_clk,
    input wire logic [7:0] line_data,
    input wire logic line_fs,
    input wire logic server_fail_in,
    input wire logic [tmsk_pkg::TRACE_W-1:0] expected_trace,
    input wire logic termination_point_mode,
    input wire logic trace_check_disable,
    input wire logic server_fail_report_en,
    input wire logic remote_defect_report_en,
    input wire logic outgoing_defect_report_en,
    input wire logic [3:0] degrade_period_count,
    input wire logic [CNT_W-1:0] degrade_threshold,
    input wire logic one_second,
    output logic trail_fail_out,
    output logic trail_degrade_out,
    output logic unequipped_cause,
    output logic conn_loss_cause,
    output logic trace_mismatch_cause,
    output logic degrade_cause,
    output logic server_fail_cause,
    output logic remote_defect_cause,
    output logic outgoing_defect_cause,
    output logic outgoing_errored_block,
    output logic [tmsk_pkg::TRACE_W-1:0] accepted_trace,
    output logic [CNT_W-1:0] near_block_count,
    output logic [CNT_W-1:0] far_block_count,
    output logic [CNT_W-1:0] outgoing_far_block_count,
    output logic near_defect_second,
    output logic far_defect_second,
    output logic outgoing_far_defect_second
);

    localparam int unsigned PW = tmsk_pkg::POS_W;
    localparam int unsigned TW = tmsk_pkg::TRACE_W;

    function automatic logic [3:0] ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction: ones

    // --------------------------------------------------------------
    // line clock domain: parity and overhead capture
    // --------------------------------------------------------------
    logic lrst_s1_q, lrst_q;
    logic [PW-1:0] pos_q, pos_d;
    logic [7:0] par_acc_q, par_prev_q, prev_par, nr_q;
    logic [3:0] mm_q, mm_cnt;
    logic seen_q, tog_q;
    logic [12:0] bund_q;
    logic em_hit, nr_hit;

    assign pos_d = line_fs ? '0 : pos_q + 1'b1;
    assign em_hit = pos_d == PW'(EM_POS);
    assign nr_hit = pos_d == PW'(NR_POS);
    assign prev_par = line_fs ? par_acc_q : par_prev_q;
    assign mm_cnt = ones(line_data ^ prev_par); // [RQ1]

    always_ff @(posedge line_clk) begin
        lrst_s1_q <= rst;
        lrst_q <= lrst_s1_q;
    end

    // results travel one frame late, held stable a whole frame
    always_ff @(posedge line_clk) begin
        if (lrst_q) begin
            pos_q <= '0;
            par_acc_q <= 8'h00;
            par_prev_q <= 8'h00;
            nr_q <= 8'h00;
            mm_q <= 4'h0;
            seen_q <= 1'b0;
            tog_q <= 1'b0;
            bund_q <= 13'h0000;
        end else begin
            pos_q <= pos_d;
            par_acc_q <= line_fs ? line_data : par_acc_q ^ line_data; // [RQ1]
            if (line_fs) begin
                par_prev_q <= par_acc_q;
            end
            if (em_hit) begin
                mm_q <= mm_cnt; // [RQ1]
            end
            if (nr_hit) begin
                nr_q <= line_data;
            end
            if (line_fs) begin
                seen_q <= 1'b1;
                bund_q <= {server_fail_in, mm_q, nr_q};
                tog_q <= tog_q ^ seen_q;
            end
        end
    end

    // --------------------------------------------------------------
    // crossing into ref_clk: toggle with stable bundle
    // --------------------------------------------------------------
    logic tg_s1_q, tg_s2_q, tg_s3_q, frame_evt_q, new_frame;
    logic [7:0] nr_r_q;
    logic [3:0] mm_r_q;
    logic ssf_q;

    assign new_frame = tg_s2_q ^ tg_s3_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            tg_s3_q <= 1'b0;
            frame_evt_q <= 1'b0;
            nr_r_q <= 8'h00;
            mm_r_q <= 4'h0;
            ssf_q <= 1'b0;
        end else begin
            tg_s1_q <= tog_q;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
            frame_evt_q <= new_frame;
            if (new_frame) begin
                {ssf_q, mm_r_q, nr_r_q} <= bund_q;
            end
        end
    end

    // --------------------------------------------------------------
    // overhead decode and block errors
    // --------------------------------------------------------------
    logic [3:0] iec, diff;
    logic rei, oei, mb7, mb8;
    logic near_blk, far_blk, ofar_blk;

    assign iec = nr_r_q[7:4]; // [RQ4]
    assign rei = nr_r_q[3]; // [RQ7]
    assign oei = nr_r_q[2]; // [RQ9]
    assign mb7 = nr_r_q[1];
    assign mb8 = nr_r_q[0];
    assign diff = (mm_r_q >= iec) ? mm_r_q - iec : iec - mm_r_q; // [RQ2]
    assign near_blk = frame_evt_q && diff != 4'h0; // [RQ2]
    assign far_blk = frame_evt_q && rei; // [RQ7]
    assign ofar_blk = frame_evt_q && oei; // [RQ9]

    // --------------------------------------------------------------
    // multiframe alignment
    // --------------------------------------------------------------
    tmsk_pkg::tmsk_mf_t mf_st_q;
    logic [11:0] fas_q, fas_d;
    logic [6:0] mf_pos_q, pos_nx;
    logic fas_ok, fas_err_q, in_mf, fas_chk, conn_loss_defect;

    assign fas_d = {fas_q[9:0], mb7, mb8};
    assign fas_ok = fas_d == tmsk_pkg::FAS_PAT; // [RQ10]
    assign pos_nx = (mf_pos_q == tmsk_pkg::MF_LEN) ? 7'h01 : mf_pos_q + 7'h01;
    assign in_mf = mf_st_q == tmsk_pkg::TMSK_IM;
    assign fas_chk = in_mf && pos_nx == tmsk_pkg::FAS_END;
    assign conn_loss_defect = !in_mf; // [RQ14]

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mf_st_q <= tmsk_pkg::TMSK_OOM;
            fas_q <= 12'h000;
            mf_pos_q <= 7'h01;
            fas_err_q <= 1'b0;
        end else if (frame_evt_q) begin
            fas_q <= fas_d;
            case (mf_st_q)
                tmsk_pkg::TMSK_OOM: begin
                    if (fas_ok) begin
                        mf_st_q <= tmsk_pkg::TMSK_IM; // [RQ12]
                        mf_pos_q <= tmsk_pkg::FAS_END;
                        fas_err_q <= 1'b0;
                    end
                end
                tmsk_pkg::TMSK_IM: begin
                    mf_pos_q <= pos_nx;
                    if (fas_chk) begin
                        fas_err_q <= !fas_ok;
                        if (!fas_ok && fas_err_q) begin
                            mf_st_q <= tmsk_pkg::TMSK_OOM; // [RQ11]
                        end
                    end
                end
                default: begin
                    mf_st_q <= tmsk_pkg::TMSK_OOM;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // trace recovery, acceptance and mismatch
    // --------------------------------------------------------------
    // mode 1 only: 16 byte trace, no legacy single byte handling
    logic [TW-1:0] rx_q, rx_d, last_q;
    logic [1:0] same_q, same_d;
    logic tti_win, tti_end, trace_mismatch_defect;

    assign rx_d = {rx_q[TW-3:0], mb7, mb8};
    assign tti_win = in_mf && pos_nx >= tmsk_pkg::TTI_FIRST && pos_nx <= tmsk_pkg::TTI_LAST;
    assign tti_end = in_mf && pos_nx == tmsk_pkg::TTI_LAST;
    assign same_d = (rx_d != last_q) ? 2'h1 :
        (same_q == tmsk_pkg::TRACE_ACC_N) ? same_q : same_q + 2'h1;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_q <= '0;
            last_q <= '0;
            same_q <= 2'h0;
            accepted_trace <= '0;
            trace_mismatch_defect <= 1'b0;
        end else begin
            if (frame_evt_q && tti_win) begin
                rx_q <= rx_d; // [RQ5] [RQ6]
            end
            if (frame_evt_q && tti_end) begin
                last_q <= rx_d;
                same_q <= same_d;
                if (same_d == tmsk_pkg::TRACE_ACC_N) begin
                    accepted_trace <= rx_d; // [RQ5]
                end
            end
            // compared every cycle, so reaction is one ref_clk cycle
            trace_mismatch_defect <= accepted_trace != expected_trace
                && !ssf_q && !trace_check_disable; // [RQ15] [RQ16]
        end
    end

    // --------------------------------------------------------------
    // persistence filtered defects
    // --------------------------------------------------------------
    logic unequipped_defect, remote_defect, outgoing_remote_defect;

    tmsk_persist #(.N(tmsk_pkg::UNEQ_N)) u_uneq (
        .clk(ref_clk),
        .rst(rst),
        .sample(frame_evt_q),
        .bit_in(nr_r_q == tmsk_pkg::UNEQ_CODE), // [RQ13]
        .state_q(unequipped_defect)
    );

    tmsk_persist #(.N(tmsk_pkg::REMOTE_N)) u_rdi (
        .clk(ref_clk),
        .rst(rst),
        .sample(frame_evt_q && in_mf && pos_nx == tmsk_pkg::RDI_POS), // [RQ7]
        .bit_in(mb8), // [RQ8] [RQ18]
        .state_q(remote_defect)
    );

    tmsk_persist #(.N(tmsk_pkg::REMOTE_N)) u_odi (
        .clk(ref_clk),
        .rst(rst),
        .sample(frame_evt_q && in_mf && pos_nx == tmsk_pkg::ODI_POS), // [RQ9]
        .bit_in(mb7), // [RQ18]
        .state_q(outgoing_remote_defect)
    );

    // --------------------------------------------------------------
    // degrade over one-second intervals
    // --------------------------------------------------------------
    logic [CNT_W-1:0] sec_err_q, sec_err_now;
    logic [3:0] deg_run_q;
    logic degrade_defect, sec_bad, deg_flip;

    assign sec_err_now = sec_err_q + CNT_W'(near_blk);
    assign sec_bad = sec_err_now >= degrade_threshold; // [RQ17]
    assign deg_flip = sec_bad != degrade_defect && deg_run_q + 4'h1 >= degrade_period_count;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sec_err_q <= '0;
            deg_run_q <= 4'h0;
            degrade_defect <= 1'b0;
        end else if (one_second) begin
            sec_err_q <= '0;
            if (sec_bad == degrade_defect || deg_flip) begin
                deg_run_q <= 4'h0;
            end else begin
                deg_run_q <= deg_run_q + 4'h1;
            end
            if (deg_flip) begin
                degrade_defect <= sec_bad; // [RQ17]
            end
        end else begin
            sec_err_q <= sec_err_now;
        end
    end

    // --------------------------------------------------------------
    // consequent actions and correlation
    // --------------------------------------------------------------
    logic ssf_en_q, rdi_en_q, odi_en_q, mon, tsf, rem_ok;

    assign mon = termination_point_mode == tmsk_pkg::TPM_MON; // [RQ24]
    assign tsf = ssf_q || unequipped_defect || trace_mismatch_defect
        || conn_loss_defect; // [RQ19]
    assign rem_ok = !unequipped_defect && !trace_mismatch_defect && !conn_loss_defect;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ssf_en_q <= tmsk_pkg::REPORT_EN_RST; // [RQ22]
            rdi_en_q <= tmsk_pkg::REPORT_EN_RST;
            odi_en_q <= tmsk_pkg::REPORT_EN_RST;
            trail_fail_out <= 1'b0;
            trail_degrade_out <= 1'b0;
            unequipped_cause <= 1'b0;
            conn_loss_cause <= 1'b0;
            trace_mismatch_cause <= 1'b0;
            degrade_cause <= 1'b0;
            server_fail_cause <= 1'b0;
            remote_defect_cause <= 1'b0;
            outgoing_defect_cause <= 1'b0;
            outgoing_errored_block <= 1'b0;
        end else begin
            ssf_en_q <= server_fail_report_en;
            rdi_en_q <= remote_defect_report_en;
            odi_en_q <= outgoing_defect_report_en;
            trail_fail_out <= tsf; // [RQ19]
            trail_degrade_out <= degrade_defect; // [RQ19]
            unequipped_cause <= mon && unequipped_defect; // [RQ20]
            conn_loss_cause <= mon && !unequipped_defect && conn_loss_defect;
            trace_mismatch_cause <= mon && !unequipped_defect && !conn_loss_defect
                && trace_mismatch_defect; // [RQ20]
            degrade_cause <= mon && !trace_mismatch_defect && !conn_loss_defect
                && degrade_defect; // [RQ20]
            server_fail_cause <= mon && ssf_q && ssf_en_q; // [RQ21]
            remote_defect_cause <= mon && rem_ok && remote_defect && rdi_en_q;
            outgoing_defect_cause <= mon && rem_ok && outgoing_remote_defect
                && odi_en_q; // [RQ21]
            outgoing_errored_block <= frame_evt_q && mm_r_q != 4'h0; // [RQ3]
        end
    end

    // --------------------------------------------------------------
    // per-second performance counters
    // --------------------------------------------------------------
    // an event in the closing cycle lands in the closing second
    logic [CNT_W-1:0] acc_q [3];
    logic [CNT_W-1:0] cnt_q [3];
    logic ds_acc_q [3], ds_q [3];
    logic [2:0] ev_blk, ev_ds;

    assign ev_blk = {ofar_blk, far_blk, near_blk};
    assign ev_ds = {outgoing_remote_defect, remote_defect, trail_fail_out};

    for (genvar i = 0; i < 3; i++) begin : g_pm
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                acc_q[i] <= '0;
                cnt_q[i] <= '0;
                ds_acc_q[i] <= 1'b0;
                ds_q[i] <= 1'b0;
            end else if (one_second) begin
                cnt_q[i] <= acc_q[i] + CNT_W'(ev_blk[i]); // [RQ23]
                ds_q[i] <= ds_acc_q[i] || ev_ds[i];
                acc_q[i] <= '0;
                ds_acc_q[i] <= 1'b0;
            end else begin
                acc_q[i] <= acc_q[i] + CNT_W'(ev_blk[i]);
                ds_acc_q[i] <= ds_acc_q[i] || ev_ds[i];
            end
        end
    end

    assign near_block_count = cnt_q[0];
    assign far_block_count = cnt_q[1];
    assign outgoing_far_block_count = cnt_q[2];
    assign near_defect_second = ds_q[0];
    assign far_defect_second = ds_q[1];
    assign outgoing_far_defect_second = ds_q[2];

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    fas_loss_a: assert property ( // [RQ11]
        frame_evt_q && fas_chk && !fas_ok && fas_err_q |=> !in_mf)
        else $error("aligner kept lock after two bad patterns");

    fas_hold_a: assert property ( // [RQ11]
        frame_evt_q && fas_chk && !fas_err_q |=> in_mf && conn_loss_defect == 1'b0)
        else $error("aligner lost lock after a single bad pattern");

    mf_regain_a: assert property ( // [RQ12]
        frame_evt_q && !in_mf && fas_ok |=> in_mf && mf_pos_q == tmsk_pkg::FAS_END)
        else $error("aligner missed a clean pattern");

    tsf_set_a: assert property ( // [RQ19]
        ssf_q || unequipped_defect || trace_mismatch_defect || !in_mf |=> trail_fail_out)
        else $error("trail fail not raised");

    tim_supp_a: assert property ( // [RQ16]
        ssf_q || trace_check_disable |=> !trace_mismatch_defect)
        else $error("trace mismatch not suppressed");

    cause_excl_a: assert property ( // [RQ20]
        conn_loss_cause |-> !unequipped_cause && !trace_mismatch_cause)
        else $error("connection loss cause not prioritised");

    rdi_gate_a: assert property ( // [RQ21]
        remote_defect_cause |-> $past(rdi_en_q && mon && rem_ok && remote_defect))
        else $error("remote cause reported without its conditions");

    en_reset_a: assert property ( // [RQ22]
        $fell(rst) |-> !ssf_en_q && !rdi_en_q && !odi_en_q)
        else $error("report enables not cleared by reset");

    near_cnt_a: assert property ( // [RQ2]
        near_blk && !one_second |=> acc_q[0] == $past(acc_q[0]) + CNT_W'(1))
        else $error("near errored block not counted");

    regain_c: cover property (frame_evt_q && !in_mf && fas_ok);
    uneq_c: cover property ($rose(unequipped_cause));
    deg_c: cover property ($rose(degrade_defect));
    rdi_c: cover property ($rose(remote_defect_cause));

endmodule: tmsk_sink

`default_nettype wire

// [verif/tmsk_far_src.sv]
// far-end tandem source model: back-to-back 6-byte frames on line_clk
// assumes controls change just after line_fs, so each frame sees one set
`default_nettype none
module tmsk_far_src (
    input wire logic line_clk,
    input wire logic uneq,
    input wire logic [7:0] flip,
    input wire logic [3:0] iec,
    input wire logic rei,
    input wire logic rdi,
    input wire logic odi,
    input wire logic [127:0] trace,
    output logic [7:0] line_data,
    output logic line_fs
);
    timeunit 1ns;
    timeprecision 1ns;
    int pos = 0;
    int mfp = 0;
    logic [7:0] acc = 8'h00;
    logic [7:0] prv = 8'h00;
    logic [1:0] b78;
    logic [7:0] byt;
    // ----
    // frame content
    // ----
    always_comb begin
        b78 = 2'h0;
        if (mfp < 5) b78 = 2'h3;
        else if (mfp == 5) b78 = 2'h2;
        else if (mfp >= 8 && mfp <= 71) b78 = {trace[143-2*mfp], trace[142-2*mfp]};
        else if (mfp == 72) b78 = {1'b0, rdi};
        else if (mfp == 73) b78 = {odi, 1'b0};
    end
    // parity byte carries previous frame parity, flip injects errors
    assign byt = (pos == 2) ? (prv ^ flip) : (pos == 5) ? (uneq ? 8'h00 : {iec, rei, rei, b78})
        : 8'(pos * 17 + mfp);
    always @(posedge line_clk) begin
        line_data <= byt;
        line_fs <= (pos == 0);
        acc <= (pos == 0) ? byt : (acc ^ byt);
        if (pos == 0) prv <= acc;
        if (pos == 5) mfp <= (mfp == 75) ? 0 : mfp + 1;
        pos <= (pos == 5) ? 0 : pos + 1;
    end
endmodule: tmsk_far_src
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the tandem monitor sink
// assumes the far source model; ref_clk 8 ns, line_clk 80 ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [127:0] TR = {16{8'h5a}};
    localparam int MF = 76;
    localparam logic [7:0] FL [4] = '{8'h01, 8'h81, 8'h03, 8'h07};
    localparam logic [3:0] IE [4] = '{4'h0, 4'h2, 4'h0, 4'h1};
    logic ref_clk = 0, rst = 1, line_clk = 0, server_fail_in = 0, one_second = 0, line_fs;
    logic termination_point_mode = 1, trace_check_disable = 0, uneq = 0, rei = 0, rdi = 0;
    logic server_fail_report_en = 0, remote_defect_report_en = 0, odi = 0;
    logic outgoing_defect_report_en = 0, trail_fail_out, trail_degrade_out, unequipped_cause;
    logic [127:0] expected_trace = TR, accepted_trace;
    logic [7:0] flip = 8'h00, line_data;
    logic [3:0] iec = 4'h0, degrade_period_count = 4'h1;
    logic [13:0] degrade_threshold = 14'h3, near_block_count, far_block_count;
    logic [13:0] outgoing_far_block_count;
    logic conn_loss_cause, trace_mismatch_cause, degrade_cause, server_fail_cause;
    logic remote_defect_cause, outgoing_defect_cause, outgoing_errored_block;
    logic near_defect_second, far_defect_second, outgoing_far_defect_second;
    int miscompares = 0, n_compared = 0, oeb_n = 0;
    initial forever #4 ref_clk = ~ref_clk;
    initial begin
        #3;
        forever #40 line_clk = ~line_clk;
    end
    always @(posedge ref_clk) oeb_n <= oeb_n + int'(outgoing_errored_block);
    tmsk_sink u_tmsk_sink (.ref_clk, .rst, .line_clk, .line_data, .line_fs, .server_fail_in,
        .expected_trace, .termination_point_mode, .trace_check_disable, .server_fail_report_en,
        .remote_defect_report_en, .outgoing_defect_report_en, .degrade_period_count,
        .degrade_threshold, .one_second, .trail_fail_out, .trail_degrade_out, .unequipped_cause,
        .conn_loss_cause, .trace_mismatch_cause, .degrade_cause, .server_fail_cause,
        .remote_defect_cause, .outgoing_defect_cause, .outgoing_errored_block, .accepted_trace,
        .near_block_count, .far_block_count, .outgoing_far_block_count, .near_defect_second,
        .far_defect_second, .outgoing_far_defect_second);
    tmsk_far_src u_tmsk_far_src (.line_clk, .uneq, .flip, .iec, .rei, .rdi, .odi, .trace(TR),
        .line_data, .line_fs);
    // ----
    // helpers
    // ----
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask: tick
    task automatic frames(input int n);
        repeat (n) @(posedge line_fs);
        tick(1);
    endtask: frames
    task automatic pulse_second();
        one_second = 1;
        tick(1);
        one_second = 0;
        tick(4);
    endtask: pulse_second
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask: wrap_up
    initial begin
        repeat (80000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
    // ----
    // scenarios
    // ----
    initial begin
        int b;
        tick(20);
        rst = 0;
        tick(4);
        `CHK("ltc", 1'b1, conn_loss_cause)
        frames(5 * MF);
        `CHK("ltc", 1'b0, conn_loss_cause)
        `CHK("trace", TR, accepted_trace)
        `CHK("tsf", 1'b0, trail_fail_out)
        pulse_second();
        pulse_second();
        b = oeb_n;
        for (int i = 0; i < 4; i++) begin
            frames(1);
            flip = FL[i];
            iec = IE[i];
            rei = (i < 3);
        end
        frames(1);
        flip = 0;
        iec = 0;
        rei = 0;
        frames(2);
        pulse_second();
        `CHK("near", 14'h3, near_block_count)
        `CHK("far", 14'h3, far_block_count)
        `CHK("ofar", 14'h3, outgoing_far_block_count)
        `CHK("oeb", 4, oeb_n - b)
        `CHK("tsd", 1'b1, trail_degrade_out)
        `CHK("deg", 1'b1, degrade_cause)
        `CHK("nds", 1'b0, near_defect_second)
        pulse_second();
        `CHK("tsd", 1'b0, trail_degrade_out)
        uneq = 1;
        frames(4);
        `CHK("uneq", 1'b0, unequipped_cause)
        frames(2 * MF);
        `CHK("uneq", 1'b1, unequipped_cause)
        `CHK("ltc", 1'b0, conn_loss_cause)
        `CHK("tsf", 1'b1, trail_fail_out)
        uneq = 0;
        frames(4);
        `CHK("uneq", 1'b1, unequipped_cause)
        frames(2 * MF);
        `CHK("uneq", 1'b0, unequipped_cause)
        `CHK("tsf", 1'b0, trail_fail_out)
        expected_trace = ~TR;
        tick(10);
        `CHK("tim", 1'b1, trace_mismatch_cause)
        trace_check_disable = 1;
        tick(10);
        `CHK("tim", 1'b0, trace_mismatch_cause)
        trace_check_disable = 0;
        server_fail_in = 1;
        server_fail_report_en = 1;
        frames(2);
        `CHK("tim", 1'b0, trace_mismatch_cause)
        `CHK("ssf", 1'b1, server_fail_cause)
        termination_point_mode = 0;
        tick(10);
        `CHK("ssf", 1'b0, server_fail_cause)
        `CHK("tsf", 1'b1, trail_fail_out)
        termination_point_mode = 1;
        server_fail_in = 0;
        expected_trace = TR;
        rdi = 1;
        odi = 1;
        remote_defect_report_en = 1;
        outgoing_defect_report_en = 1;
        frames(5 * MF + 4);
        `CHK("rdi", 1'b1, remote_defect_cause)
        `CHK("odi", 1'b1, outgoing_defect_cause)
        pulse_second();
        `CHK("fds", 1'b1, far_defect_second)
        `CHK("nds", 1'b1, near_defect_second)
        `CHK("ofds", 1'b1, outgoing_far_defect_second)
        wrap_up();
    end
endmodule: testbench
`default_nettype wire
